// ===== common/seq_params.svh
/*
 constants for the program sequencer and indirect pointer block.
 assumes inclusion by bare name from the design files.
*/
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH
// register byte offsets on the register bus
`define OFF_PTR_LOW 8'h00
`define OFF_IND_PTR 8'h04
`define OFF_IND_PORT 8'h08
`define OFF_IP_FULL 8'h0c
`define OFF_PAGE 8'h10
`define OFF_STACK1 8'h14
`define OFF_STACK2 8'h18
`define OFF_ACC 8'h1c
// address of the indirect access port in data space
`define IND_PORT_ADDR 7'h00
// bank field of the indirect pointer
`define BANK_LSB 5
// jump field width
`define JUMP_BITS 9
`define LOW_BITS 8
`define PAGE_LSB 9
// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ===== common/seq_pkg.sv
/*
 types shared by the sequencer files.
 assumes nothing of its surroundings.
*/
package seq_pkg;
   typedef enum logic [2:0]
   {
      OP_STEP = 3'b000,
      OP_JUMP = 3'b001,
      OP_CALL = 3'b010,
      OP_RET = 3'b011,
      OP_LOWWR = 3'b100
   } op_type;
endpackage : seq_pkg

// ===== src/return_stack.sv
/*
 two level return stack.
 assumes push and pop never both high.
*/
`timescale 1ns/1ps
`default_nettype none
module return_stack #(
   parameter int W = 11
) (
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic push, // call
   input wire logic pop, // literal return
   input wire logic [W-1:0] push_val, // return address
   output logic [W-1:0] level1, // stack top
   output logic [W-1:0] level2 // second level
);
   logic [W-1:0] l1_q;
   logic [W-1:0] l2_q;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         l1_q <= '0;
         l2_q <= '0;
      end
      else if (push)
      begin
         l2_q <= l1_q;
         l1_q <= push_val;
      end
      else if (pop)
         l1_q <= l2_q;
   end
   assign level1 = l1_q;
   assign level2 = l2_q;
   a_push_order: assert property (@(posedge clk) disable iff (!rst_n)
      push |=> (l2_q == $past(l1_q) && l1_q == $past(push_val)))
      else $error("push order wrong");
   a_pop_keep: assert property (@(posedge clk) disable iff (!rst_n)
      pop |=> (l1_q == $past(l2_q) && $stable(l2_q)))
      else $error("pop order wrong");
endmodule : return_stack
`default_nettype wire

// ===== src/indirect_unit.sv
/*
 indirect pointer register and address redirection.
 assumes a data memory outside that takes mem_addr and mem_we.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module indirect_unit #(
   parameter int FW = 7,
   parameter bit BANKED = 1'b1
) (
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset
   input wire logic ptr_we, // write pointer
   input wire logic [7:0] ptr_wdata, // pointer data
   input wire logic [6:0] acc_addr, // direct address
   input wire logic acc_we, // data write
   output logic [6:0] ptr_view, // pointer as read
   output logic [6:0] mem_addr, // redirected address
   output logic mem_we, // gated write
   output logic port_null // pointer selects the port itself
);
   logic [FW-1:0] ptr_q;
   logic [6:0] ptr_full;
   logic is_port;
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         ptr_q <= '0;
      else if (ptr_we)
         ptr_q <= ptr_wdata[FW-1:0];
   end
   generate
      if (BANKED && FW == 7)
      begin : g_bank
         assign ptr_full = ptr_q;
      end
      else if (FW == 6)
      begin : g_six
         assign ptr_full = {1'b1, ptr_q};
      end
      else
      begin : g_flat
         assign ptr_full = {2'b11, ptr_q[4:0]};
      end
   endgenerate
   assign ptr_view = ptr_full;
   assign is_port = (acc_addr[4:0] == 5'(`IND_PORT_ADDR));
   // bank bits only reach memory on banked parts
   wire [6:0] ind_addr = BANKED ? ptr_full : {2'b00, ptr_full[4:0]};
   assign mem_addr = is_port ? ind_addr : acc_addr;
   assign port_null = is_port && (ind_addr[4:0] == 5'(`IND_PORT_ADDR));
   assign mem_we = acc_we && !port_null;
   a_null_write: assert property (@(posedge clk) disable iff (!rst_n)
      (acc_we && acc_addr[4:0] == 5'(`IND_PORT_ADDR) && ptr_q[4:0] == 5'(`IND_PORT_ADDR))
      |-> !mem_we)
      else $error("write through null pointer");
endmodule : indirect_unit
`default_nettype wire

// ===== src/program_sequencer.sv
/*
 program sequencer with return stack, indirect pointer and axi4-lite registers.
 assumes the decoder gives one op per instruction cycle (one clk) and that the
 data memory returns mem_rdata combinationally for mem_addr.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module program_sequencer #(
   parameter int PW = 11, // pointer width 9, 10 or 11
   parameter int FW = 7, // indirect pointer width 5, 6 or 7
   parameter bit BANKED = 1'b1
) (
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset
   input wire seq_pkg::op_type op, // decoded sequencing op
   input wire logic [11:0] instr, // instruction word
   input wire logic [7:0] alu_result, // result for low byte writes
   input wire logic [6:0] data_addr, // direct data address
   input wire logic data_we, // data write request
   input wire logic [7:0] mem_rdata, // data memory read value
   output logic [PW-1:0] instr_ptr, // next instruction address
   output logic [6:0] mem_addr, // data memory address
   output logic mem_we, // data memory write
   output logic [7:0] read_data, // data read with null pointer handled
   output logic [7:0] accumulator, // working accumulator
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready // read data ready
);
   localparam bit PAGED = (PW > `JUMP_BITS);
   logic [PW-1:0] ip_q;
   logic [PW-1:0] ip_d;
   logic [1:0] page_q;
   logic [7:0] acc_q;
   logic [PW-1:0] lvl1;
   logic [PW-1:0] lvl2;
   logic [PW-1:0] ip_inc;
   logic [PW-1:0] page_ext;
   logic sw_low_we;
   logic sw_page_we;
   logic sw_ptr_we;
   logic sw_port_we;
   logic [6:0] ptr_view;
   logic [6:0] ind_addr;
   logic ind_we;
   logic port_null;
   logic [6:0] sel_addr;
   logic sel_we;
   // axi write and read channel state
   logic aw_have_q;
   logic w_have_q;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] rd_mux;
   logic rd_hit;

   assign ip_inc = ip_q + {{(PW-1){1'b0}}, 1'b1};
   // page bits above bit 8 on paged parts only
   generate
      if (PW > `JUMP_BITS)
      begin : g_paged
         logic [1:0] page_src;
         assign page_src = page_q;
         assign page_ext = {page_src[PW-`JUMP_BITS-1:0], {`JUMP_BITS{1'b0}}};
      end
      else
      begin : g_flat
         assign page_ext = '0;
      end
   endgenerate

   // software writes to the low byte act as a modify of the pointer
   assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
   assign sw_low_we = wr_fire && (aw_addr_q == `OFF_PTR_LOW) && w_strb_q[0];
   assign sw_page_we = wr_fire && (aw_addr_q == `OFF_PAGE) && w_strb_q[0];
   assign sw_ptr_we = wr_fire && (aw_addr_q == `OFF_IND_PTR) && w_strb_q[0];
   assign sw_port_we = wr_fire && (aw_addr_q == `OFF_IND_PORT) && w_strb_q[0];

   always_comb
   begin
      ip_d = ip_inc;
      if (sw_low_we)
         ip_d = page_ext | {{(PW-`LOW_BITS){1'b0}}, w_data_q[7:0]};
      else
      begin
         case (op)
            seq_pkg::OP_JUMP: ip_d = page_ext | PW'(instr[`JUMP_BITS-1:0]);
            seq_pkg::OP_CALL: ip_d = page_ext | {{(PW-`LOW_BITS){1'b0}}, instr[7:0]};
            seq_pkg::OP_LOWWR: ip_d = page_ext | {{(PW-`LOW_BITS){1'b0}}, alu_result};
            seq_pkg::OP_RET: ip_d = lvl1;
            default: ip_d = ip_inc;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         ip_q <= '1;
         page_q <= 2'b00;
         acc_q <= 8'h00;
      end
      else
      begin
         ip_q <= ip_d;
         if (sw_page_we && PAGED)
            page_q <= w_data_q[1:0];
         if (op == seq_pkg::OP_RET)
            acc_q <= instr[7:0];
      end
   end

   return_stack #(.W(PW)) u_stack (
      .clk(clk),
      .rst_n(rst_n),
      .push(op == seq_pkg::OP_CALL && !sw_low_we),
      .pop(op == seq_pkg::OP_RET && !sw_low_we),
      .push_val(ip_inc),
      .level1(lvl1),
      .level2(lvl2)
   );

   // bus writes to the indirect port enter as port accesses and reach memory at the pointer address
   assign sel_addr = sw_port_we ? `IND_PORT_ADDR : data_addr;
   assign sel_we = sw_port_we | data_we;

   indirect_unit #(.FW(FW), .BANKED(BANKED)) u_ind (
      .clk(clk),
      .rst_n(rst_n),
      .ptr_we(sw_ptr_we),
      .ptr_wdata(w_data_q[7:0]),
      .acc_addr(sel_addr),
      .acc_we(sel_we),
      .ptr_view(ptr_view),
      .mem_addr(ind_addr),
      .mem_we(ind_we),
      .port_null(port_null)
   );
   assign mem_addr = ind_addr;
   assign mem_we = ind_we;
   assign read_data = port_null ? 8'h00 : mem_rdata;
   assign instr_ptr = ip_q;
   assign accumulator = acc_q;

   // axi4-lite write side: address and data taken in either order
   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign wr_hit = (aw_addr_q == `OFF_PTR_LOW) || (aw_addr_q == `OFF_IND_PTR)
      || (aw_addr_q == `OFF_IND_PORT) || (aw_addr_q == `OFF_PAGE);
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && !aw_have_q)
         begin
            aw_have_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_have_q)
         begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (bvalid_q && s_axi_bready)
         begin
            bvalid_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;

   // axi4-lite read side
   assign s_axi_arready = !rvalid_q;
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      rd_hit = 1'b1;
      case (s_axi_araddr)
         `OFF_PTR_LOW: rd_mux = {24'h000000, ip_q[7:0]};
         `OFF_IND_PTR: rd_mux = {25'h0, ptr_view};
         `OFF_IND_PORT: rd_mux = 32'h0000_0000;
         `OFF_IP_FULL: rd_mux = {{(32-PW){1'b0}}, ip_q};
         `OFF_PAGE: rd_mux = {30'h0, page_q};
         `OFF_STACK1: rd_mux = {{(32-PW){1'b0}}, lvl1};
         `OFF_STACK2: rd_mux = {{(32-PW){1'b0}}, lvl2};
         `OFF_ACC: rd_mux = {24'h000000, acc_q};
         default: rd_hit = 1'b0;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `RESP_OKAY;
      end
      else if (s_axi_arvalid && !rvalid_q)
      begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (rvalid_q && s_axi_rready)
         rvalid_q <= 1'b0;
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   sequence s_call_seen;
      (op == seq_pkg::OP_CALL) && !sw_low_we;
   endsequence
   a_step_inc: assert property (@(posedge clk) disable iff (!rst_n)
      (op == seq_pkg::OP_STEP && !sw_low_we) |=> ip_q == $past(ip_q) + 1'b1)
      else $error("pointer did not advance");
   a_jump_load: assert property (@(posedge clk) disable iff (!rst_n)
      (op == seq_pkg::OP_JUMP && !sw_low_we) |=> ip_q[8:0] == $past(instr[8:0]))
      else $error("jump field not loaded");
   a_call_bit8: assert property (@(posedge clk) disable iff (!rst_n)
      s_call_seen |=> (ip_q[8] == 1'b0 && ip_q[7:0] == $past(instr[7:0])))
      else $error("call bit 8 not cleared");
   a_call_ret: assert property (@(posedge clk) disable iff (!rst_n)
      s_call_seen ##1 (op == seq_pkg::OP_RET && !sw_low_we)
      |=> ip_q == $past(ip_q, 2) + 1'b1)
      else $error("return address wrong");
   a_ret_acc: assert property (@(posedge clk) disable iff (!rst_n)
      (op == seq_pkg::OP_RET) |=> acc_q == $past(instr[7:0]))
      else $error("literal not loaded");
   a_reset_vec: assert property (@(posedge clk)
      !rst_n |=> (ip_q == '1 && page_q == 2'b00))
      else $error("reset vector wrong");
   a_page_keep: assert property (@(posedge clk) disable iff (!rst_n)
      !sw_page_we |=> $stable(page_q))
      else $error("page bits changed");
   a_low_view: assert property (@(posedge clk) disable iff (!rst_n)
      rvalid_q && $past(s_axi_araddr == `OFF_PTR_LOW && s_axi_arvalid && !rvalid_q)
      |-> rdata_q[7:0] == $past(ip_q[7:0]))
      else $error("low byte read wrong");
endmodule : program_sequencer
`default_nettype wire

// ===== tb/tb_program_sequencer.sv
/*
 self-checking bench for program_sequencer: sequencing ops, stack, indirect pointer, registers.
 assumes the design files, seq_pkg and seq_params.svh are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "seq_params.svh"
module tb_program_sequencer;
   logic clk, rst_n, data_we, mem_we;
   seq_pkg::op_type op;
   logic [11:0] instr;
   logic [7:0] alu_result, mem_rdata, read_data, accumulator;
   logic [6:0] data_addr, mem_addr;
   logic [10:0] instr_ptr, wr_ptr;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [8:0] ip2;
   logic [6:0] mem_addr2;
   logic [31:0] rdata2, rd2;
   int failures, checks;

   program_sequencer #(.PW(11), .FW(7), .BANKED(1'b1)) DUT (
      .clk(clk), .rst_n(rst_n), .op(op), .instr(instr), .alu_result(alu_result),
      .data_addr(data_addr), .data_we(data_we), .mem_rdata(mem_rdata), .instr_ptr(instr_ptr),
      .mem_addr(mem_addr), .mem_we(mem_we), .read_data(read_data), .accumulator(accumulator),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
   );

   // unbanked, unpaged variant on the same stimulus
   program_sequencer #(.PW(9), .FW(5), .BANKED(1'b0)) DUT2 (
      .clk(clk), .rst_n(rst_n), .op(op), .instr(instr), .alu_result(alu_result),
      .data_addr(data_addr), .data_we(data_we), .mem_rdata(mem_rdata), .instr_ptr(ip2),
      .mem_addr(mem_addr2), .mem_we(), .read_data(), .accumulator(),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
      .s_axi_rdata(rdata2), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(s_axi_rready)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // write address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      logic aw_pend, w_pend, aw_go, w_go;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_pend = 1'b1;
      w_pend = 1'b1;
      n = 0;
      while ((aw_pend || w_pend) && n < 100)
      begin
         #1;
         aw_go = s_axi_awready;
         w_go = s_axi_wready;
         @(posedge clk);
         n++;
         if (aw_pend && aw_go === 1'b1)
         begin
            s_axi_awvalid <= 1'b0;
            aw_pend = 1'b0;
         end
         if (w_pend && w_go === 1'b1)
         begin
            s_axi_wvalid <= 1'b0;
            w_pend = 1'b0;
         end
      end
      while (n < 100)
      begin
         #1;
         if (s_axi_bvalid === 1'b1)
            break;
         @(posedge clk);
         n++;
      end
      wr_ptr = instr_ptr;
      chk(s_axi_bresp, er);
      @(posedge clk);
      s_axi_bready <= 1'b0;
      if (n >= 100)
         failures++;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      logic go;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      n = 0;
      while (n < 100)
      begin
         #1;
         go = s_axi_arready;
         @(posedge clk);
         n++;
         if (go === 1'b1)
            break;
      end
      s_axi_arvalid <= 1'b0;
      while (n < 100)
      begin
         #1;
         if (s_axi_rvalid === 1'b1)
            break;
         @(posedge clk);
         n++;
      end
      chk(s_axi_rdata, ed);
      chk(s_axi_rresp, er);
      rd2 = rdata2;
      @(posedge clk);
      s_axi_rready <= 1'b0;
      if (n >= 100)
         failures++;
   endtask : rd

   // the op for one cycle, then back to step, then outputs viewed at the falling edge
   task automatic exec(input seq_pkg::op_type o, input logic [11:0] i);
      @(posedge clk);
      op <= o;
      instr <= i;
      @(posedge clk);
      op <= seq_pkg::OP_STEP;
      @(negedge clk);
   endtask : exec

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   initial
   begin
      #200000;
      failures++;
      summarize();
   end

   initial
   begin
      rst_n = 1'b0;
      op = seq_pkg::OP_STEP;
      instr = 12'h000;
      alu_result = 8'h00;
      data_addr = 7'h00;
      data_we = 1'b0;
      mem_rdata = 8'h00;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'h0;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      repeat (9) @(posedge clk);
      @(negedge clk);
      chk(instr_ptr, 11'h7ff);
      chk(ip2, 9'h1ff);
      @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      @(negedge clk);
      chk(instr_ptr, 11'h000);
      @(negedge clk);
      chk(instr_ptr, 11'h001);
      chk(accumulator, 8'h00);
      rd(`OFF_PAGE, 32'h0, `RESP_OKAY);
      $display("test reset done");
      wr(`OFF_PAGE, 32'h1, `RESP_OKAY);
      exec(seq_pkg::OP_JUMP, 12'h123);
      chk(instr_ptr, 11'h323);
      chk(ip2, 9'h123);
      wr(`OFF_PAGE, 32'h2, `RESP_OKAY);
      exec(seq_pkg::OP_CALL, 12'h1ab);
      chk(instr_ptr, 11'h4ab);
      wr(`OFF_PAGE, 32'h0, `RESP_OKAY);
      exec(seq_pkg::OP_JUMP, 12'h1fe);
      exec(seq_pkg::OP_STEP, 12'h000);
      chk(instr_ptr, 11'h200);
      rd(`OFF_PAGE, 32'h0, `RESP_OKAY);
      exec(seq_pkg::OP_JUMP, 12'h045);
      chk(instr_ptr, 11'h045);
      $display("test paging done");
      exec(seq_pkg::OP_JUMP, 12'h010);
      exec(seq_pkg::OP_CALL, 12'h1a0);
      chk(instr_ptr, 11'h0a0);
      exec(seq_pkg::OP_CALL, 12'h0b0);
      exec(seq_pkg::OP_CALL, 12'h0c0);
      rd(`OFF_STACK1, 32'h0b2, `RESP_OKAY);
      rd(`OFF_STACK2, 32'h0a2, `RESP_OKAY);
      exec(seq_pkg::OP_RET, 12'h07e);
      chk(instr_ptr, 11'h0b2);
      chk(accumulator, 8'h7e);
      exec(seq_pkg::OP_RET, 12'h055);
      chk(instr_ptr, 11'h0a2);
      chk(accumulator, 8'h55);
      exec(seq_pkg::OP_RET, 12'h011);
      chk(instr_ptr, 11'h0a2);
      // call straight into return: pointer 0a3 pushes 0a4
      @(posedge clk);
      op <= seq_pkg::OP_CALL;
      instr <= 12'h033;
      @(posedge clk);
      op <= seq_pkg::OP_RET;
      instr <= 12'h099;
      @(posedge clk);
      op <= seq_pkg::OP_STEP;
      @(negedge clk);
      chk(instr_ptr, 11'h0a4);
      chk(accumulator, 8'h99);
      rd(`OFF_STACK1, 32'h0a2, `RESP_OKAY);
      $display("test stack done");
      wr(`OFF_PAGE, 32'h3, `RESP_OKAY);
      wr(`OFF_PTR_LOW, 32'h5c, `RESP_OKAY);
      chk(wr_ptr, 11'h65c);
      alu_result <= 8'h3d;
      exec(seq_pkg::OP_LOWWR, 12'h000);
      chk(instr_ptr, 11'h63d);
      @(posedge clk);
      op <= seq_pkg::OP_LOWWR;
      rd(`OFF_PTR_LOW, 32'h3d, `RESP_OKAY);
      rd(`OFF_IP_FULL, 32'h63d, `RESP_OKAY);
      op <= seq_pkg::OP_STEP;
      rd(8'h20, 32'h0, `RESP_SLVERR);
      wr(8'h24, 32'h1, `RESP_SLVERR);
      $display("test registers done");
      for (int b = 0; b < 4; b++)
      begin
         wr(`OFF_IND_PTR, {25'h0, 2'(b), 5'h07}, `RESP_OKAY);
         @(posedge clk);
         data_addr <= `IND_PORT_ADDR;
         data_we <= 1'b1;
         mem_rdata <= 8'h3c;
         @(negedge clk);
         chk(mem_addr, {2'(b), 5'h07});
         chk(mem_we, 1'b1);
         chk(read_data, 8'h3c);
      end
      wr(`OFF_IND_PTR, 32'h4a, `RESP_OKAY);
      rd(`OFF_IND_PTR, 32'h4a, `RESP_OKAY);
      chk(rd2, 32'h6a);
      @(negedge clk);
      chk(mem_addr, 7'h4a);
      chk(mem_addr2, 7'h0a);
      wr(`OFF_IND_PTR, 32'h60, `RESP_OKAY);
      rd(`OFF_IND_PTR, 32'h60, `RESP_OKAY);
      @(negedge clk);
      chk(mem_we, 1'b0);
      chk(read_data, 8'h00);
      @(posedge clk);
      data_addr <= 7'h2a;
      @(negedge clk);
      chk(mem_addr, 7'h2a);
      chk(mem_we, 1'b1);
      $display("test indirect done");
      summarize();
   end
endmodule : tb_program_sequencer
`default_nettype wire
